// ==== hw/smbsl_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module smbsl_top #(
  parameter int REG_DEPTH = smbsl_pkg::REG_DEPTH_DEF
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic smb_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic addr_enable_i,
  input wire logic slave_addr_bit_zero_i,
  input wire logic [7:0] status_i,
  input wire logic alert_enable_i,
  output logic alert_o,
  output logic alert_oe_n_o
);

  localparam int AW = $clog2(REG_DEPTH);

  // ****************************************
  // Link domain state, clocked by smb_clk_i
  // ****************************************
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic en_m;
    logic en_s;
    logic sel_m;
    logic sel_s;
    logic [7:0] stat_m;
    logic [7:0] stat_s;
    logic [7:0] stat_d;
    logic [7:0] stat_q;
    smbsl_pkg::smbsl_state_t st;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic rw;
    logic hit;
    logic [1:0] nbytes;
    logic lock;
    logic [6:0] addr;
    logic [7:0] ptr;
    logic [REG_DEPTH-1:0][7:0] regs;
    logic [7:0] mask;
    logic mask_tgl;
    logic [7:0] rd_sr;
    logic oe_n;
    logic sda_lo;
  } smbsl_link_t;

  // ****************************************
  // System domain state, clocked by sys_clk_i
  // ****************************************
  typedef struct packed {
    logic tg_m;
    logic tg_s;
    logic tg_d;
    logic [7:0] mask;
    logic alert_oe_n;
    logic drv_lo;
  } smbsl_sys_t;

  smbsl_link_t lr, ln;
  smbsl_sys_t sr_r, sr_nxt;

  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic [6:0] sel_addr;
  logic [6:0] strap_addr;
  logic [7:0] rd_value;
  logic [7:0] wr_byte;

  // ****************************************
  // Bus events from the synchronised lines
  // ****************************************
  assign scl_rise = lr.scl_s & ~lr.scl_d;
  assign scl_fall = ~lr.scl_s & lr.scl_d;
  assign start_ev = lr.scl_s & lr.scl_d & lr.sda_d & ~lr.sda_s;
  assign stop_ev = lr.scl_s & lr.scl_d & ~lr.sda_d & lr.sda_s;

  // Strap address follows the pins only until the first match locks it
  assign strap_addr = lr.en_s ? smbsl_pkg::ADDR_DEFAULT :
    (smbsl_pkg::ADDR_SEL_BASE | {6'h00, lr.sel_s});
  assign sel_addr = lr.lock ? lr.addr : strap_addr;

  // Status bits are synchronised one by one, so they may settle on different
  // edges; the read copy only follows once two samples agree, so a read never
  // mixes bits of two status words, at the cost of two link clocks of delay
  always_comb begin
    rd_value = smbsl_pkg::RD_UNMAPPED;
    if (lr.ptr == smbsl_pkg::STATUS_ADDR) begin
      rd_value = lr.stat_q;
    end else if (lr.ptr == smbsl_pkg::MASK_ADDR) begin
      rd_value = lr.mask;
    end else if (int'(lr.ptr) < REG_DEPTH) begin
      rd_value = lr.regs[lr.ptr[AW-1:0]];
    end
  end

  assign wr_byte = lr.sr;

  // ****************************************
  // Link domain next state
  // ****************************************
  always_comb begin
    ln = lr;
    ln.scl_m = scl_i;
    ln.scl_s = lr.scl_m;
    ln.scl_d = lr.scl_s;
    ln.sda_m = sda_i;
    ln.sda_s = lr.sda_m;
    ln.sda_d = lr.sda_s;
    ln.en_m = addr_enable_i;
    ln.en_s = lr.en_m;
    ln.sel_m = slave_addr_bit_zero_i;
    ln.sel_s = lr.sel_m;
    ln.stat_m = status_i;
    ln.stat_s = lr.stat_m;
    ln.stat_d = lr.stat_s;
    if (lr.stat_s == lr.stat_d) begin
      ln.stat_q = lr.stat_d;
    end
    if (stop_ev) begin
      ln.st = smbsl_pkg::ST_IDLE;
      ln.oe_n = 1'b1;
      ln.cnt = 4'h0;
    end else if (start_ev) begin
      ln.st = smbsl_pkg::ST_ADDR;
      ln.oe_n = 1'b1;
      ln.cnt = 4'h0;
      ln.hit = 1'b0;
    end else begin
      case (lr.st)
        smbsl_pkg::ST_IDLE, smbsl_pkg::ST_WAIT: begin
          ln.oe_n = 1'b1;
        end
        smbsl_pkg::ST_ADDR: begin
          if (scl_rise) begin
            ln.sr = {lr.sr[6:0], lr.sda_s};
            ln.cnt = lr.cnt + 4'h1;
            if (lr.cnt == smbsl_pkg::ADDR_LATCH_CNT) begin
              ln.hit = (lr.sr[6:0] == sel_addr);
              if (lr.sr[6:0] == sel_addr && !lr.lock) begin
                ln.lock = 1'b1;
                ln.addr = strap_addr;
              end
            end
          end else if (scl_fall && lr.cnt == smbsl_pkg::BYTE_BITS) begin
            ln.rw = lr.sr[0];
            ln.nbytes = 2'h0;
            if (lr.hit) begin
              ln.st = smbsl_pkg::ST_AACK;
              ln.oe_n = 1'b0;
            end else begin
              ln.st = smbsl_pkg::ST_WAIT;
            end
          end
        end
        smbsl_pkg::ST_AACK: begin
          if (scl_fall) begin
            ln.cnt = 4'h0;
            if (lr.rw) begin
              ln.st = smbsl_pkg::ST_RD;
              ln.rd_sr = rd_value;
              ln.oe_n = rd_value[7];
            end else begin
              ln.st = smbsl_pkg::ST_WR;
              ln.oe_n = 1'b1;
            end
          end
        end
        smbsl_pkg::ST_WR: begin
          if (scl_rise) begin
            ln.sr = {lr.sr[6:0], lr.sda_s};
            ln.cnt = lr.cnt + 4'h1;
          end else if (scl_fall && lr.cnt == smbsl_pkg::BYTE_BITS) begin
            ln.nbytes = lr.nbytes + 2'h1;
            if (lr.nbytes == 2'h0) begin
              ln.ptr = wr_byte;
              ln.st = smbsl_pkg::ST_WACK;
              ln.oe_n = 1'b0;
            end else if (lr.nbytes == 2'h1) begin
              if (lr.ptr == smbsl_pkg::MASK_ADDR) begin
                ln.mask = wr_byte;
                ln.mask_tgl = ~lr.mask_tgl;
              end else if (int'(lr.ptr) < REG_DEPTH) begin
                ln.regs[lr.ptr[AW-1:0]] = wr_byte;
              end
              ln.st = smbsl_pkg::ST_WACK;
              ln.oe_n = 1'b0;
            end else begin
              ln.st = smbsl_pkg::ST_WAIT;
            end
          end
        end
        smbsl_pkg::ST_WACK: begin
          if (scl_fall) begin
            ln.oe_n = 1'b1;
            ln.cnt = 4'h0;
            ln.st = (lr.nbytes == smbsl_pkg::WR_MAX_BYTES) ?
              smbsl_pkg::ST_WAIT : smbsl_pkg::ST_WR;
          end
        end
        smbsl_pkg::ST_RD: begin
          if (scl_rise) begin
            ln.cnt = lr.cnt + 4'h1;
          end else if (scl_fall) begin
            if (lr.cnt == smbsl_pkg::BYTE_BITS) begin
              ln.oe_n = 1'b1;
              ln.st = smbsl_pkg::ST_RACK;
            end else begin
              ln.rd_sr = {lr.rd_sr[6:0], 1'b0};
              ln.oe_n = lr.rd_sr[6];
            end
          end
        end
        smbsl_pkg::ST_RACK: begin
          // Only one byte per read: acknowledge or not, the slave waits for a stop or a repeated start
          if (scl_rise) begin
            ln.st = smbsl_pkg::ST_WAIT;
          end
        end
        default: begin
          ln.st = smbsl_pkg::ST_IDLE;
          ln.oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge smb_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lr <= '{scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
        en_m: 1'b0, en_s: 1'b0, sel_m: 1'b0, sel_s: 1'b0, stat_m: 8'h00, stat_s: 8'h00,
        stat_d: 8'h00, stat_q: 8'h00,
        st: smbsl_pkg::ST_IDLE, cnt: 4'h0, sr: 8'h00, rw: 1'b0, hit: 1'b0, nbytes: 2'h0,
        lock: 1'b0, addr: 7'h00, ptr: smbsl_pkg::PTR_RST,
        regs: {REG_DEPTH{smbsl_pkg::REG_RST}}, mask: smbsl_pkg::MASK_RST,
        mask_tgl: 1'b0, rd_sr: 8'h00, oe_n: 1'b1, sda_lo: 1'b0};
    end else begin
      lr <= ln;
    end
  end

  // ****************************************
  // System domain: mask handover and alert
  // ****************************************
  // The link mask only changes with a toggle and then holds for a whole byte,
  // far longer than the synchroniser, so it is sampled safely on the edge
  always_comb begin
    sr_nxt = sr_r;
    sr_nxt.tg_m = lr.mask_tgl;
    sr_nxt.tg_s = sr_r.tg_m;
    sr_nxt.tg_d = sr_r.tg_s;
    if (sr_r.tg_s ^ sr_r.tg_d) begin
      sr_nxt.mask = lr.mask;
    end
    sr_nxt.alert_oe_n = ~(alert_enable_i & |(status_i & ~sr_r.mask));
    sr_nxt.drv_lo = 1'b0;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sr_r <= '{tg_m: 1'b0, tg_s: 1'b0, tg_d: 1'b0, mask: smbsl_pkg::MASK_RST,
        alert_oe_n: 1'b1, drv_lo: 1'b0};
    end else begin
      sr_r <= sr_nxt;
    end
  end

  // Open drain: the drive value is a register held low, only the enable moves
  assign sda_o = lr.sda_lo;
  assign sda_oe_n_o = lr.oe_n;
  assign alert_o = sr_r.drv_lo;
  assign alert_oe_n_o = sr_r.alert_oe_n;

  // ****************************************
  // Checks
  // ****************************************
  AST_DEFAULT_ADDR: assert property (@(posedge smb_clk_i) disable iff (reset_i)
    !lr.lock && lr.en_s |-> sel_addr == 7'h2E)
    else $error("default address not selected");

  AST_SEL_ADDR: assert property (@(posedge smb_clk_i) disable iff (reset_i)
    !lr.lock && !lr.en_s |-> sel_addr == {6'h16, lr.sel_s})
    else $error("strap-selected address wrong");

  AST_LOCK_HOLD: assert property (@(posedge smb_clk_i) disable iff (reset_i)
    lr.lock |=> lr.lock && $stable(lr.addr))
    else $error("latched address changed");

  AST_LOCK_AT_EIGHTH: assert property (@(posedge smb_clk_i) disable iff (reset_i)
    $rose(lr.lock) |-> $past(lr.st) == smbsl_pkg::ST_ADDR && lr.cnt == 4'h8)
    else $error("address latched at wrong clock");

  AST_ACK_ON_MATCH: assert property (@(posedge smb_clk_i) disable iff (reset_i)
    lr.st == smbsl_pkg::ST_ADDR && scl_fall && lr.cnt == 4'h8 && lr.hit && !start_ev && !stop_ev
    |=> !lr.oe_n && lr.st == smbsl_pkg::ST_AACK)
    else $error("matching address not acknowledged");

  AST_IDLE_ON_MISS: assert property (@(posedge smb_clk_i) disable iff (reset_i)
    lr.st == smbsl_pkg::ST_ADDR && scl_fall && lr.cnt == 4'h8 && !lr.hit && !start_ev && !stop_ev
    |=> lr.oe_n [*2])
    else $error("foreign address drove SDA");

  AST_STOP_RELEASE: assert property (@(posedge smb_clk_i) disable iff (reset_i)
    stop_ev |=> lr.st == smbsl_pkg::ST_IDLE && sda_oe_n_o)
    else $error("stop did not release the bus");

  AST_START_FRESH: assert property (@(posedge smb_clk_i) disable iff (reset_i)
    start_ev && !stop_ev |=> lr.st == smbsl_pkg::ST_ADDR && lr.cnt == 4'h0)
    else $error("start not taken as new address phase");

  AST_PTR_LOAD: assert property (@(posedge smb_clk_i) disable iff (reset_i)
    lr.st == smbsl_pkg::ST_WR && scl_fall && lr.cnt == 4'h8 && lr.nbytes == 2'h0 && !start_ev && !stop_ev
    |=> lr.ptr == $past(lr.sr))
    else $error("pointer not loaded from first byte");

  AST_THIRD_BYTE: assert property (@(posedge smb_clk_i) disable iff (reset_i)
    lr.st == smbsl_pkg::ST_WACK && scl_fall && lr.nbytes == 2'h2 && !start_ev && !stop_ev
    |=> lr.st == smbsl_pkg::ST_WAIT)
    else $error("more than two write bytes accepted");

  AST_READ_DIR: assert property (@(posedge smb_clk_i) disable iff (reset_i)
    lr.st == smbsl_pkg::ST_AACK && scl_fall && lr.rw && !start_ev && !stop_ev
    |=> lr.st == smbsl_pkg::ST_RD && lr.rd_sr == $past(rd_value))
    else $error("read not started from pointed register");

  AST_ALERT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    alert_enable_i && |(status_i & ~sr_r.mask) |=> !alert_oe_n_o)
    else $error("alert not driven for unmasked status");

  AST_ALERT_MASKED: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !(|(status_i & ~sr_r.mask)) |=> alert_oe_n_o)
    else $error("masked status drove alert");

  COV_WRITE_BYTE: cover property (@(posedge smb_clk_i) disable iff (reset_i)
    lr.st == smbsl_pkg::ST_WACK && lr.nbytes == 2'h2);
  COV_READ: cover property (@(posedge smb_clk_i) disable iff (reset_i)
    lr.st == smbsl_pkg::ST_RACK);
  COV_LOCK: cover property (@(posedge smb_clk_i) disable iff (reset_i) $rose(lr.lock));
  COV_ALERT: cover property (@(posedge sys_clk_i) disable iff (reset_i) $fell(alert_oe_n_o));

endmodule

`default_nettype wire

// ==== hw/smbsl_pkg.sv ====
package smbsl_pkg;

  // ****************************************
  // Slave addresses
  // ****************************************
  localparam logic [6:0] ADDR_DEFAULT = 7'h2E;
  localparam logic [6:0] ADDR_SEL_BASE = 7'h2C;

  // ****************************************
  // Byte framing
  // ****************************************
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ADDR_LATCH_CNT = 4'h7;
  localparam logic [1:0] WR_MAX_BYTES = 2'h2;
  localparam int REG_DEPTH_DEF = 16;

  // ****************************************
  // Internal register locations and resets
  // ****************************************
  localparam logic [7:0] STATUS_ADDR = 8'h41;
  localparam logic [7:0] MASK_ADDR = 8'h74;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ****************************************
  // Bus engine states, Gray coded along the path
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_WR = 3'h2,
    ST_WACK = 3'h6,
    ST_RD = 3'h7,
    ST_RACK = 3'h5,
    ST_WAIT = 3'h4
  } smbsl_state_t;

endpackage

// ==== sim/smbsl_host.sv ====
`timescale 1ns/10ps
`default_nettype none

// ****************
// Host master model
// ****************
// SCL is high for six link clocks and low for twelve per bit, above the four the slave needs
module smbsl_host (
  input wire logic smb_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic half();
    repeat (6) @(posedge smb_clk_i);
  endtask

  // Also serves as repeated start, since it first frees SDA with SCL low
  task automatic start();
    half();
    sda_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_o <= 1'b0;
    half();
    scl_o <= 1'b0;
  endtask

  // SDA moves only in the low phase; it is sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    half();
    sda_o <= b;
    half();
    scl_o <= 1'b1;
    half();
    r = sda_i;
    scl_o <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask

  task automatic stop();
    half();
    sda_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_o <= 1'b1;
    half();
  endtask
endmodule

`default_nettype wire

// ==== sim/smbus_slave_register_access_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module smbus_slave_register_access_tb;
  logic sys_clk;
  logic smb_clk;
  logic reset;
  logic addr_en;
  logic sel0;
  logic [7:0] status;
  logic alert_en;
  wire host_scl;
  wire host_sda;
  wire sda_o;
  wire sda_oe_n;
  wire alert_o;
  wire alert_oe_n;
  wire sda_w;
  int miscompares;
  int comparisons;

  // Open-drain wire with pull-up: low if either party pulls it
  assign sda_w = host_sda & (sda_oe_n | sda_o);

  smbsl_top DUT (
    .sys_clk_i(sys_clk),
    .reset_i(reset),
    .smb_clk_i(smb_clk),
    .scl_i(host_scl),
    .sda_i(sda_w),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n),
    .addr_enable_i(addr_en),
    .slave_addr_bit_zero_i(sel0),
    .status_i(status),
    .alert_enable_i(alert_en),
    .alert_o(alert_o),
    .alert_oe_n_o(alert_oe_n)
  );

  smbsl_host host (
    .smb_clk_i(smb_clk),
    .sda_i(sda_w),
    .scl_o(host_scl),
    .sda_o(host_sda)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    smb_clk = 1'b0;
    #7;
    forever #15 smb_clk = ~smb_clk;
  end

  // ****************
  // Shared helpers
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic en, input logic s0);
    @(posedge sys_clk);
    reset <= 1'b1;
    addr_en <= en;
    sel0 <= s0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (10) @(posedge smb_clk);
  endtask

  task automatic open_op(input logic [6:0] a, input logic rw, output logic ack);
    host.start();
    host.wr({a, rw}, ack);
  endtask

  task automatic probe(input logic [6:0] a, input logic exp);
    logic ack;
    open_op(a, 1'b0, ack);
    host.stop();
    chk({7'h00, ack}, {7'h00, exp});
  endtask

  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d, input int n);
    logic ack;
    open_op(7'h2E, 1'b0, ack);
    chk({7'h00, ack}, 8'h01);
    host.wr(p, ack);
    chk({7'h00, ack}, 8'h01);
    if (n > 1) begin
      host.wr(d, ack);
      chk({7'h00, ack}, 8'h01);
    end
    host.stop();
  endtask

  task automatic rd_reg(input logic [7:0] exp);
    logic ack;
    logic [7:0] d;
    open_op(7'h2E, 1'b1, ack);
    chk({7'h00, ack}, 8'h01);
    host.rd(d, 1'b1);
    host.stop();
    chk(d, exp);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_write_read();
    logic ack;
    wr_reg(8'h03, 8'h5A, 2);
    wr_reg(8'h05, 8'hA5, 2);
    open_op(7'h2E, 1'b0, ack);
    host.wr(8'h03, ack);
    chk({7'h00, ack}, 8'h01);
    rd_reg(8'h5A);
    rd_reg(8'h5A);
  endtask

  task automatic t_limits();
    logic ack;
    open_op(7'h2E, 1'b0, ack);
    host.wr(8'h06, ack);
    host.wr(8'h11, ack);
    host.wr(8'h22, ack);
    chk({7'h00, ack}, 8'h00);
    host.stop();
    rd_reg(8'h11);
    wr_reg(8'h05, 8'h00, 1);
    rd_reg(8'hA5);
    wr_reg(8'h50, 8'h77, 2);
    rd_reg(8'h00);
    probe(7'h2C, 1'b0);
  endtask

  // A stop in mid-byte must not store the partial data
  task automatic t_stop_mid();
    logic ack;
    logic r;
    open_op(7'h2E, 1'b0, ack);
    host.wr(8'h07, ack);
    repeat (4) host.bit_io(1'b1, r);
    host.stop();
    rd_reg(8'h00);
  endtask

  task automatic t_alert();
    @(posedge sys_clk);
    alert_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({6'h00, alert_o, alert_oe_n}, 8'h01);
    status <= 8'h04;
    repeat (3) @(posedge sys_clk);
    chk({6'h00, alert_o, alert_oe_n}, 8'h00);
    alert_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({7'h00, alert_oe_n}, 8'h01);
    alert_en <= 1'b1;
    wr_reg(8'h74, 8'h04, 2);
    repeat (10) @(posedge sys_clk);
    chk({7'h00, alert_oe_n}, 8'h01);
    rd_reg(8'h04);
    status <= 8'h0C;
    repeat (3) @(posedge sys_clk);
    chk({7'h00, alert_oe_n}, 8'h00);
    wr_reg(8'h41, 8'h00, 1);
    rd_reg(8'h0C);
  endtask

  task automatic t_strap();
    do_reset(1'b0, 1'b0);
    probe(7'h2D, 1'b0);
    probe(7'h2C, 1'b1);
    @(posedge sys_clk);
    sel0 <= 1'b1;
    addr_en <= 1'b1;
    repeat (10) @(posedge smb_clk);
    probe(7'h2C, 1'b1);
    probe(7'h2E, 1'b0);
    do_reset(1'b0, 1'b1);
    probe(7'h2D, 1'b1);
  endtask

  initial begin
    reset = 1'b1;
    addr_en = 1'b1;
    sel0 = 1'b0;
    status = 8'h00;
    alert_en = 1'b0;
    miscompares = 0;
    comparisons = 0;
    do_reset(1'b1, 1'b0);
    t_write_read();
    t_limits();
    t_stop_mid();
    t_alert();
    t_strap();
    stop_test();
  end

  // The full run needs well under a fifth of this span
  initial begin
    repeat (80000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end
endmodule

`default_nettype wire
